//--- verilog/pan_annunciator.v
// panel annunciator: leds, sounder, command keys, pin check, navigation
//
// Functional notes
// - mains present: power led steady, sounder silent.
// - on battery: power led flashes, sounder 0.5 s on 9.5 s off.
// - fire latched until reset: red led on, continuous tone.
// - gas latched until reset: blue led on, 0.5 s on 1.5 s off.
// - supervisory: yellow led on, 0.5 s on 3.5 s off.
// - silenced led on after silence key or auto-silence expiry.
// - silenced led off when nothing silenced or condition cleared.
// - trouble led on, 0.5/9.5 s beep: init, trouble or bypass.
// - trouble led flashes silently: panel not operating or walk test.
// - trouble led off with no trouble and during panel reset.
// - brief beep on every key press.
// - reset key: sounder off, points and outputs back to normal.
// - drill key: unbypassed notification circuits and drill relays on.
// - silence key quiets audible appliances for alarm or trouble.
// - ack stops sounder; optionally starts investigation or reminder.
// - level 2, 3 or restricted 1 needs four-digit code checked.
// - normal screen when quiet; day variant with delayed alarm mode.
// - events grouped; up/down step event, left/right change group.
// - event list opens on highest-priority event.
`timescale 1ns/1ps
`include "pan_regs.vh"
module pan_annunciator #(
    parameter NOTIF = 4,
    parameter RELAYS = 8,
    parameter TICK_CYC = `PAN_TICK_CYC,
    parameter BEEP_CYC = `PAN_BEEP_CYC
) (
    input wire ref_clk_i,
    input wire srst_i,
    input wire mains_ok_i,
    input wire battery_ok_i,
    input wire fire_i,
    input wire gas_i,
    input wire sup_i,
    input wire trouble_i,
    input wire bypass_i,
    input wire init_i,
    input wire not_oper_i,
    input wire walk_i,
    input wire auto_sil_i,
    input wire key_drill_i,
    input wire key_reset_i,
    input wire key_silence_i,
    input wire key_ack_i,
    input wire key_up_i,
    input wire key_down_i,
    input wire key_left_i,
    input wire key_right_i,
    input wire key_other_i,
    input wire [NOTIF-1:0] notif_bypass_i,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg led_power_o,
    output reg led_fire_o,
    output reg led_gas_o,
    output reg led_sup_o,
    output reg led_silenced_o,
    output reg led_trouble_o,
    output reg sounder_o,
    output reg [NOTIF-1:0] notification_circuit_o,
    output reg [RELAYS-1:0] relay_o,
    output reg invest_start_o,
    output reg reminder_start_o,
    output reg panel_reset_o,
    output reg normal_msg_o,
    output reg day_msg_o
);
    ////////////////////////////////////////////////////////////////////
    // synchronisers
    wire [21:0] raw = {mains_ok_i, battery_ok_i, fire_i, gas_i, sup_i,
        trouble_i, bypass_i, init_i, not_oper_i, walk_i, auto_sil_i,
        key_drill_i, key_reset_i, key_silence_i, key_ack_i, key_up_i,
        key_down_i, key_left_i, key_right_i, key_other_i, 2'b00};
    wire [21:0] s;
    reg [8:0] keys_q;
    pan_sync #(.W(22)) u_sync (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .async_i(raw),
        .sync_o(s)
    );
    wire mains = s[21];
    wire batt = s[20];
    wire fire_in = s[19];
    wire gas_in = s[18];
    wire sup = s[17];
    wire trb_in = s[16] | s[15] | s[14];
    wire not_op = s[13] | s[12];
    wire auto_sil = s[11];
    wire [8:0] kp = s[10:2] & ~keys_q;
    wire k_drill = kp[8];
    wire k_reset = kp[7];
    wire k_sil = kp[6];
    wire k_ack = kp[5];
    wire any_key = |kp;

    ////////////////////////////////////////////////////////////////////
    // slow tick and beep timer
    reg [31:0] tick_cnt_q;
    reg tick_q;
    reg [31:0] beep_cnt_q;
    reg flash_q;
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            tick_cnt_q <= 32'h0;
            tick_q <= 1'b0;
            flash_q <= 1'b0;
            beep_cnt_q <= 32'h0;
            keys_q <= 9'h0;
        end else begin
            keys_q <= s[10:2];
            tick_q <= (tick_cnt_q == TICK_CYC - 1);
            if (tick_cnt_q == TICK_CYC - 1) begin
                tick_cnt_q <= 32'h0;
                flash_q <= ~flash_q;
            end else begin
                tick_cnt_q <= tick_cnt_q + 32'h1;
            end
            if (any_key)
                beep_cnt_q <= BEEP_CYC;
            else if (beep_cnt_q != 32'h0)
                beep_cnt_q <= beep_cnt_q - 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // latched conditions and key actions
    reg fire_q;
    reg gas_q;
    reg sil_q;
    reg quiet_q;
    reg drill_q;
    reg rst_busy_q;
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            fire_q <= 1'b0;
            gas_q <= 1'b0;
            sil_q <= 1'b0;
            quiet_q <= 1'b0;
            drill_q <= 1'b0;
            rst_busy_q <= 1'b0;
        end else begin
            rst_busy_q <= k_reset;
            if (k_reset) begin
                fire_q <= 1'b0;
                gas_q <= 1'b0;
                sil_q <= 1'b0;
                quiet_q <= 1'b0;
                drill_q <= 1'b0;
            end else begin
                if (fire_in)
                    fire_q <= 1'b1;
                if (gas_in)
                    gas_q <= 1'b1;
                if (k_drill)
                    drill_q <= 1'b1;
                if ((k_sil || auto_sil) && (fire_q || gas_q || trb_in))
                    sil_q <= 1'b1;
                else if (!(fire_q || gas_q || trb_in))
                    sil_q <= 1'b0;
                if (k_ack || k_sil)
                    quiet_q <= 1'b1;
                else if (fire_in && !fire_q)
                    quiet_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // cadences
    wire c_bat;
    wire c_gas;
    wire c_sup;
    wire c_trb;
    pan_cadence #(.PERIOD(`PAN_PER_BAT)) u_cbat (
        .ref_clk_i(ref_clk_i), .srst_i(srst_i), .tick_i(tick_q),
        .act_i(!mains && batt), .on_o(c_bat));
    pan_cadence #(.PERIOD(`PAN_PER_GAS)) u_cgas (
        .ref_clk_i(ref_clk_i), .srst_i(srst_i), .tick_i(tick_q),
        .act_i(gas_q), .on_o(c_gas));
    pan_cadence #(.PERIOD(`PAN_PER_SUP)) u_csup (
        .ref_clk_i(ref_clk_i), .srst_i(srst_i), .tick_i(tick_q),
        .act_i(sup), .on_o(c_sup));
    pan_cadence #(.PERIOD(`PAN_PER_TRB)) u_ctrb (
        .ref_clk_i(ref_clk_i), .srst_i(srst_i), .tick_i(tick_q),
        .act_i(trb_in && !not_op), .on_o(c_trb));

    ////////////////////////////////////////////////////////////////////
    // registers over apb
    reg [5:0] ctrl_q;
    reg [15:0] pin_q;
    reg auth_ok_q;
    reg [RELAYS-1:0] drill_en_q;
    reg [1:0] grp_q;
    reg [7:0] idx_q;
    wire [3:0] grp_act = {trb_in, sup, gas_q, fire_q};
    wire acc = psel && penable;
    wire need_pin = (ctrl_q[`PAN_B_AUTH_LVL] >= 2'd2) ||
        ctrl_q[`PAN_B_RESTRICT];
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            ctrl_q <= 6'h0;
            pin_q <= `PAN_PIN_RST;
            auth_ok_q <= 1'b0;
            drill_en_q <= `PAN_DRILL_EN_RST;
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                prdata <= 32'h0;
                case (paddr)
                    `PAN_A_CTRL: prdata <= {26'h0, ctrl_q};
                    `PAN_A_STAT: prdata <= {24'h0, auth_ok_q, sil_q,
                        drill_q, fire_q, gas_q, sup, trb_in, not_op};
                    `PAN_A_PIN: prdata <= {{(32-RELAYS){1'b0}}, drill_en_q};
                    `PAN_A_NAV: prdata <= {22'h0, grp_q, idx_q};
                    `PAN_A_EVT: prdata <= {28'h0, grp_act};
                    default: pslverr <= 1'b1;
                endcase
                if (!pwrite && (paddr > `PAN_A_EVT))
                    pslverr <= 1'b1;
            end
            if (k_reset)
                auth_ok_q <= 1'b0;
            if (acc && pwrite && pready) begin
                case (paddr)
                    `PAN_A_CTRL: begin
                        ctrl_q <= pwdata[5:0];
                        auth_ok_q <= 1'b0;
                    end
                    `PAN_A_PIN: begin
                        if (pwdata[31])
                            drill_en_q <= pwdata[RELAYS-1:0];
                        else
                            auth_ok_q <= !need_pin ||
                                (pwdata[15:0] == pin_q);
                    end
                    `PAN_A_NAV: begin
                        if (auth_ok_q)
                            pin_q <= pwdata[15:0];
                    end
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // event navigation
    reg [3:0] prev_act_q;
    reg [1:0] g_nx;
    integer j;
    always @* begin
        g_nx = grp_q;
        for (j = 3; j >= 0; j = j - 1)
            if (grp_act[j])
                g_nx = j[1:0];
    end
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            grp_q <= 2'd0;
            idx_q <= 8'h0;
            prev_act_q <= 4'h0;
        end else begin
            prev_act_q <= grp_act;
            if (prev_act_q == 4'h0 && grp_act != 4'h0) begin
                grp_q <= g_nx;
                idx_q <= 8'h0;
            end else if (kp[2]) begin
                grp_q <= grp_q - 2'd1;
                idx_q <= 8'h0;
            end else if (kp[1]) begin
                grp_q <= grp_q + 2'd1;
                idx_q <= 8'h0;
            end else if (kp[4] && idx_q != 8'h0) begin
                idx_q <= idx_q - 8'h1;
            end else if (kp[3]) begin
                idx_q <= idx_q + 8'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    integer n;
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            led_power_o <= 1'b0;
            led_fire_o <= 1'b0;
            led_gas_o <= 1'b0;
            led_sup_o <= 1'b0;
            led_silenced_o <= 1'b0;
            led_trouble_o <= 1'b0;
            sounder_o <= 1'b0;
            notification_circuit_o <= {NOTIF{1'b0}};
            relay_o <= {RELAYS{1'b0}};
            invest_start_o <= 1'b0;
            reminder_start_o <= 1'b0;
            panel_reset_o <= 1'b0;
            normal_msg_o <= 1'b0;
            day_msg_o <= 1'b0;
        end else begin
            led_power_o <= mains | (batt & flash_q);
            led_fire_o <= fire_q;
            led_gas_o <= gas_q;
            led_sup_o <= sup;
            led_silenced_o <= sil_q;
            if (k_reset || rst_busy_q)
                led_trouble_o <= 1'b0;
            else if (not_op)
                led_trouble_o <= flash_q;
            else
                led_trouble_o <= trb_in;
            if (k_reset || k_ack)
                sounder_o <= 1'b0;
            else if (beep_cnt_q != 32'h0)
                sounder_o <= 1'b1;
            else if (quiet_q)
                sounder_o <= 1'b0;
            else if (fire_q)
                sounder_o <= 1'b1;
            else
                sounder_o <= c_gas | c_sup | c_trb | c_bat;
            for (n = 0; n < NOTIF; n = n + 1)
                notification_circuit_o[n] <= (drill_q | fire_q) &
                    ~notif_bypass_i[n] & ~sil_q;
            relay_o <= drill_q ? drill_en_q : {RELAYS{1'b0}};
            invest_start_o <= k_ack && ctrl_q[`PAN_B_CFG_INV] &&
                (fire_q || gas_q);
            reminder_start_o <= k_ack && ctrl_q[`PAN_B_CFG_REM] &&
                trb_in;
            panel_reset_o <= k_reset;
            normal_msg_o <= (grp_act == 4'h0);
            day_msg_o <= (grp_act == 4'h0) &&
                ctrl_q[`PAN_B_DAY_MODE];
        end
    end
endmodule

//--- verilog/pan_regs.vh
// constants for the panel annunciator block
`ifndef PAN_REGS_VH
`define PAN_REGS_VH
`define PAN_CLK_HZ 200000000
`define PAN_TICK_MS 500
`define PAN_TICK_CYC ((`PAN_CLK_HZ / 1000) * `PAN_TICK_MS)
`define PAN_BEEP_US 50000
`define PAN_BEEP_CYC ((`PAN_CLK_HZ / 1000000) * `PAN_BEEP_US)
`define PAN_SLOT_W 5
`define PAN_PER_BAT 5'd20
`define PAN_PER_GAS 5'd4
`define PAN_PER_SUP 5'd8
`define PAN_PER_TRB 5'd20
`define PAN_ON_SLOTS 5'd1
`define PAN_A_CTRL 12'h000
`define PAN_A_STAT 12'h004
`define PAN_A_PIN 12'h008
`define PAN_A_NAV 12'h00c
`define PAN_A_EVT 12'h010
`define PAN_B_AUTH_LVL 1:0
`define PAN_B_RESTRICT 2
`define PAN_B_CFG_INV 3
`define PAN_B_CFG_REM 4
`define PAN_B_DAY_MODE 5
`define PAN_PIN_RST 16'h1234
`define PAN_DRILL_EN_RST 8'hff
`endif

//--- verilog/pan_sync.v
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module pan_sync #(
    parameter W = 1
) (
    input wire ref_clk_i,
    input wire srst_i,
    input wire [W-1:0] async_i,
    output reg [W-1:0] sync_o
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;
    integer i;
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            s1_q <= {W{1'b0}};
            s2_q <= {W{1'b0}};
            s3_q <= {W{1'b0}};
            sync_o <= {W{1'b0}};
        end else begin
            s1_q <= async_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (i = 0; i < W; i = i + 1) begin
                if (s2_q[i] == s3_q[i]) begin
                    sync_o[i] <= s3_q[i];
                end
            end
        end
    end
endmodule

//--- verilog/pan_cadence.v
// periodic beep cadence counted in slow ticks
`timescale 1ns/1ps
`include "pan_regs.vh"
module pan_cadence #(
    parameter [`PAN_SLOT_W-1:0] PERIOD = `PAN_PER_GAS
) (
    input wire ref_clk_i,
    input wire srst_i,
    input wire tick_i,
    input wire act_i,
    output reg on_o
);
    reg [`PAN_SLOT_W-1:0] slot_q;
    always @(posedge ref_clk_i) begin
        if (srst_i || !act_i) begin
            slot_q <= {`PAN_SLOT_W{1'b0}};
            on_o <= 1'b0;
        end else begin
            on_o <= (slot_q < `PAN_ON_SLOTS);
            if (tick_i) begin
                if (slot_q == PERIOD - `PAN_ON_SLOTS)
                    slot_q <= {`PAN_SLOT_W{1'b0}};
                else
                    slot_q <= slot_q + `PAN_ON_SLOTS;
            end
        end
    end
endmodule

//--- testbench/pan_annunciator_sva.sv
// assertion checker for the panel annunciator
`timescale 1ns/1ps
module pan_annunciator_sva #(
    parameter NOTIF = 4
) (
    input wire ref_clk_i,
    input wire srst_i,
    input wire mains_ok_i,
    input wire sup_i,
    input wire trouble_i,
    input wire not_oper_i,
    input wire walk_i,
    input wire psel,
    input wire penable,
    input wire [31:0] prdata,
    input wire pready,
    input wire led_power_o,
    input wire led_fire_o,
    input wire led_gas_o,
    input wire led_sup_o,
    input wire led_trouble_o,
    input wire [NOTIF-1:0] notif_bypass_i,
    input wire [NOTIF-1:0] notification_circuit_o,
    input wire panel_reset_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_trb;
        trouble_i && !not_oper_i && !walk_i && !panel_reset_o;
    endsequence
    chk_apb_answer: assert property (s_setup |=> pready)
        else $error("no ready after setup");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    chk_rdata_hold: assert property (!pready |-> $stable(prdata))
        else $error("read data moved outside access");
    chk_power_on: assert property (
        mains_ok_i [*8] |-> led_power_o) else $error("power led off");
    chk_sup_on: assert property (
        sup_i [*8] |-> led_sup_o) else $error("sup led off");
    chk_sup_off: assert property (
        !sup_i [*8] |-> !led_sup_o) else $error("sup led on");
    chk_trouble_on: assert property (
        s_trb [*8] |-> led_trouble_o) else $error("trouble led off");
    chk_fire_latch: assert property (
        led_fire_o |=> led_fire_o || panel_reset_o || $past(panel_reset_o))
        else $error("fire led dropped without reset");
    chk_gas_latch: assert property (
        led_gas_o |=> led_gas_o || panel_reset_o || $past(panel_reset_o))
        else $error("gas led dropped without reset");
    chk_drill_bypass: assert property (
        !(|(notification_circuit_o & $past(notif_bypass_i))))
        else $error("bypassed circuit driven");
endmodule
bind pan_annunciator pan_annunciator_sva #(.NOTIF(NOTIF)) chk_u (
    .ref_clk_i, .srst_i, .mains_ok_i, .sup_i, .trouble_i, .not_oper_i,
    .walk_i, .psel, .penable, .prdata, .pready, .led_power_o, .led_fire_o,
    .led_gas_o, .led_sup_o, .led_trouble_o, .notif_bypass_i,
    .notification_circuit_o, .panel_reset_o);

//--- testbench/pan_keypad_model.sv
// operator keypad model: timed key presses
`timescale 1ns/1ps
module pan_keypad_model (
    input wire ref_clk_i,
    output logic [8:0] keys_o
);
    initial keys_o = 9'h000;
    // hold long enough to pass the input filter
    task automatic press(input int k);
        @(posedge ref_clk_i);
        keys_o[k] <= 1'b1;
        repeat (6) @(posedge ref_clk_i);
        keys_o[k] <= 1'b0;
    endtask
endmodule

//--- testbench/pan_annunciator_test.sv
// self-checking testbench for the panel annunciator
`timescale 1ns/1ps
`include "pan_regs.vh"
module pan_annunciator_test;
    localparam int TK = 20;
    localparam int BP = 5;
    logic ref_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic mains_ok_i = 1'b1;
    logic battery_ok_i = 1'b0, fire_i = 1'b0, gas_i = 1'b0, sup_i = 1'b0;
    logic trouble_i = 1'b0, bypass_i = 1'b0, init_i = 1'b0;
    logic not_oper_i = 1'b0, walk_i = 1'b0, auto_sil_i = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] notif_bypass_i = 4'h5;
    logic [31:0] rdat;
    logic rerr;
    int fail_count = 0, tests_run = 0, cs, cp, ct, ci, cr;
    wire [8:0] keys;
    wire [31:0] prdata;
    wire pready, pslverr, led_power_o, led_fire_o, led_gas_o, led_sup_o;
    wire led_silenced_o, led_trouble_o, sounder_o, invest_start_o;
    wire reminder_start_o, panel_reset_o, normal_msg_o, day_msg_o;
    wire [3:0] notification_circuit_o;
    wire [7:0] relay_o;
    always #2.5 ref_clk_i = ~ref_clk_i;
    pan_keypad_model kp_u (.ref_clk_i, .keys_o(keys));
    pan_annunciator #(.TICK_CYC(TK), .BEEP_CYC(BP)) dut_u (
        .ref_clk_i, .srst_i, .mains_ok_i, .battery_ok_i, .fire_i, .gas_i,
        .sup_i, .trouble_i, .bypass_i, .init_i, .not_oper_i, .walk_i,
        .auto_sil_i, .key_drill_i(keys[0]), .key_reset_i(keys[1]),
        .key_silence_i(keys[2]), .key_ack_i(keys[3]), .key_up_i(keys[4]),
        .key_down_i(keys[5]), .key_left_i(keys[6]), .key_right_i(keys[7]),
        .key_other_i(keys[8]), .notif_bypass_i, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .led_power_o,
        .led_fire_o, .led_gas_o, .led_sup_o, .led_silenced_o, .led_trouble_o,
        .sounder_o, .notification_circuit_o, .relay_o, .invest_start_o,
        .reminder_start_o, .panel_reset_o, .normal_msg_o, .day_msg_o);
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        @(posedge ref_clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk_i);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdm(input logic [11:0] a, input logic [31:0] m, e);
        xfer(1'b0, a, 32'h0);
        chk(rdat & m, e);
    endtask
    task automatic meas(input int n);
        cs = 0;
        cp = 0;
        ct = 0;
        repeat (n) begin
            @(posedge ref_clk_i);
            cs += sounder_o;
            cp += led_power_o;
            ct += led_trouble_o;
        end
    endtask
    task automatic key(input int k);
        ci = 0;
        cr = 0;
        fork
            kp_u.press(k);
            repeat (37) begin
                @(posedge ref_clk_i);
                ci += invest_start_o;
                cr += reminder_start_o;
            end
        join
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        fail_count++;
        test_done();
    end
    initial begin
        cyc(2);
        srst_i <= 1'b0;
        cyc(10);
        meas(100);
        chk(cs, 0);
        chk(cp, 100);
        chk(ct, 0);
        chk(normal_msg_o, 1);
        rdm(`PAN_A_CTRL, 32'hffffffff, 0);
        rdm(`PAN_A_PIN, 32'hff, `PAN_DRILL_EN_RST);
        xfer(1'b0, 12'h020, 32'h0);
        chk(rerr, 1);
        mains_ok_i <= 1'b0;
        battery_ok_i <= 1'b1;
        cyc(10);
        meas(40 * TK);
        chk(cs, 2 * TK);
        chk(cp, 20 * TK);
        mains_ok_i <= 1'b1;
        gas_i <= 1'b1;
        cyc(10);
        gas_i <= 1'b0;
        meas(8 * TK);
        chk(cs, 2 * TK);
        rdm(`PAN_A_EVT, 32'hf, 32'h2);
        rdm(`PAN_A_NAV, 32'h3ff, 32'h100);
        key(7);
        key(5);
        rdm(`PAN_A_NAV, 32'h3ff, 32'h201);
        key(4);
        key(6);
        rdm(`PAN_A_NAV, 32'h3ff, 32'h100);
        fire_i <= 1'b1;
        cyc(10);
        fire_i <= 1'b0;
        meas(8 * TK);
        chk(cs, 8 * TK);
        key(2);
        chk(led_silenced_o, 1);
        meas(100);
        chk(cs, 0);
        rdm(`PAN_A_STAT, 32'h78, 32'h58);
        key(1);
        chk(led_silenced_o, 0);
        chk(led_fire_o, 0);
        chk(led_gas_o, 0);
        meas(80);
        chk(cs, 0);
        xfer(1'b1, `PAN_A_CTRL, 32'h18);
        fire_i <= 1'b1;
        cyc(10);
        fire_i <= 1'b0;
        key(3);
        chk(ci, 1);
        chk(cr, 0);
        meas(100);
        chk(cs, 0);
        key(1);
        sup_i <= 1'b1;
        cyc(10);
        meas(16 * TK);
        chk(cs, 2 * TK);
        sup_i <= 1'b0;
        cyc(10);
        chk(led_sup_o, 0);
        trouble_i <= 1'b1;
        cyc(10);
        meas(40 * TK);
        chk(cs, 2 * TK);
        chk(ct, 40 * TK);
        auto_sil_i <= 1'b1;
        cyc(10);
        chk(led_silenced_o, 1);
        auto_sil_i <= 1'b0;
        key(3);
        chk(cr, 1);
        chk(ci, 0);
        key(1);
        trouble_i <= 1'b0;
        bypass_i <= 1'b1;
        cyc(10);
        chk(led_trouble_o, 1);
        bypass_i <= 1'b0;
        init_i <= 1'b1;
        cyc(10);
        chk(led_trouble_o, 1);
        init_i <= 1'b0;
        walk_i <= 1'b1;
        cyc(10);
        meas(40 * TK);
        chk(cs, 0);
        chk(ct, 20 * TK);
        walk_i <= 1'b0;
        cyc(10);
        chk(led_trouble_o, 0);
        not_oper_i <= 1'b1;
        cyc(10);
        meas(4 * TK);
        chk(cs, 0);
        chk(ct, 2 * TK);
        not_oper_i <= 1'b0;
        cyc(TK * 20);
        fork
            kp_u.press(8);
            meas(40);
        join
        chk(cs, BP);
        key(0);
        chk(notification_circuit_o, {28'h0, ~notif_bypass_i});
        chk(relay_o, `PAN_DRILL_EN_RST);
        key(1);
        chk(notification_circuit_o, 0);
        xfer(1'b1, `PAN_A_CTRL, 32'h2);
        xfer(1'b1, `PAN_A_PIN, 32'h1111);
        rdm(`PAN_A_STAT, 32'h80, 32'h0);
        xfer(1'b1, `PAN_A_PIN, `PAN_PIN_RST);
        rdm(`PAN_A_STAT, 32'h80, 32'h80);
        xfer(1'b1, `PAN_A_CTRL, 32'h20);
        cyc(5);
        chk(day_msg_o, 1);
        test_done();
    end
endmodule
